// ---- logic/madr_regs.sv ----
// AHB-Lite register bank for motor algorithm debug and monitor control
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module madr_regs (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output var  logic [31:0]           hrdata,
    output var  logic                  hreadyout,
    output var  logic                  hresp,
    // Gains in use by the control loops
    input  wire madr_pkg::madr_gains_t gains_used,
    // Estimation engine handshake
    input  wire logic                  step_done,
    output var  madr_pkg::madr_step_t  meas_step,
    output var  logic                  shadow_store,
    // Monitor DAC configuration
    output var  madr_pkg::madr_dac1_t  dac1_cfg
);
    import madr_pkg::*;

    // ==================================================
    // State
    typedef struct packed {
        madr_dac1_t  dac1;
        logic        wr_valid;
        logic [7:0]  wr_idx;
        logic [31:0] rdata;
        logic        ready;
        logic        start;
        logic        store;
        logic        done;
        madr_sel_t   sel;
    } madr_state_t;

    madr_state_t st_reg;
    madr_state_t st_next;

    logic       addr_taken;
    logic [7:0] addr_idx;
    logic       seq_finished;

    // Word index of a mapped register; unmapped and unaligned give none
    function automatic logic [7:0] decode_idx(logic [31:0] a);
        logic [7:0] i;
        i = a[9:2];
        if (a[31:10] != 22'h0 || a[1:0] != 2'b00)
            return IDX_NONE;
        if (i == IDX_CUR_GAIN || i == IDX_SPD_GAIN || i == IDX_DAC1 ||
            i == IDX_DBG_CTRL || i == IDX_MEAS_STS)
            return i;
        return IDX_NONE;
    endfunction

    // Pack a pair of gains into their readback word
    function automatic logic [31:0] gain_word(logic [GAIN_W-1:0] ki,
                                              logic [GAIN_W-1:0] kp);
        logic [31:0] w;
        w = 32'h0;
        w[KI_LSB +: GAIN_W] = ki;
        w[KP_LSB +: GAIN_W] = kp;
        return w;
    endfunction

    // ==================================================
    // Address phase
    assign addr_taken = hsel && htrans[1] && hready;
    assign addr_idx   = decode_idx(haddr);

    // ==================================================
    // Measurement sequencer
    madr_meas_seq u_seq (
        .clk       (clk),
        .nrst      (nrst),
        .start     (st_reg.start),
        .sel       (st_reg.sel),
        .step_done (step_done),
        .step      (meas_step),
        .finished  (seq_finished)
    );

    // Next state: write data phase, read capture, pulses
    always_comb begin
        st_next       = st_reg;
        st_next.start = 1'b0;
        st_next.store = 1'b0;
        st_next.ready = 1'b1;
        // Hardware set wins over a software clear in the same cycle
        if (st_reg.wr_valid && st_reg.wr_idx == IDX_MEAS_STS &&
            hwdata[STS_DONE])
            st_next.done = 1'b0;
        if (seq_finished)
            st_next.done = 1'b1;
        // Data phase of a write lands here
        if (st_reg.wr_valid) begin
            case (st_reg.wr_idx)
                IDX_DAC1: begin
                    st_next.dac1 = madr_dac1_t'(hwdata[DAC1_W-1:0]);
                end
                IDX_DBG_CTRL: begin
                    // Held selects; a start in this same write uses them
                    st_next.sel.inductance_select = hwdata[BIT_IND];
                    st_next.sel.back_emf_select   = hwdata[BIT_BEMF];
                    st_next.sel.mechanical_select = hwdata[BIT_MECH];
                    st_next.start = hwdata[BIT_START];
                    st_next.store = hwdata[BIT_STORE];
                end
                // Gain readbacks ignore written data; a status write only clears done, above
                default: begin
                    st_next.dac1 = st_reg.dac1;
                end
            endcase
        end
        // Address phase: capture a write, or sample read data now
        st_next.wr_valid = addr_taken && hwrite;
        st_next.wr_idx   = addr_taken ? addr_idx : IDX_NONE;
        if (addr_taken && !hwrite) begin
            case (addr_idx)
                IDX_CUR_GAIN: begin
                    st_next.rdata = gain_word(
                        gains_used.current_integral_gain_used,
                        gains_used.current_proportional_gain_used);
                end
                IDX_SPD_GAIN: begin
                    st_next.rdata = gain_word(
                        gains_used.speed_integral_gain_used,
                        gains_used.speed_proportional_gain_used);
                end
                IDX_DAC1: begin
                    st_next.rdata = {11'h0, st_reg.dac1};
                end
                IDX_MEAS_STS: begin
                    st_next.rdata = 32'h0;
                    st_next.rdata[STS_BUSY] = meas_step != STEP_IDLE;
                    st_next.rdata[STS_DONE] = st_reg.done;
                end
                // Write-only control and unmapped words read as zero
                default: begin
                    st_next.rdata = 32'h0;
                end
            endcase
        end
    end

    // ==================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg      <= '0;
            st_reg.dac1 <= madr_dac1_t'(DAC1_RESET[DAC1_W-1:0]);
            st_reg.ready <= 1'b1;
        end else begin
            st_reg      <= st_next;
        end
    end

    // ==================================================
    // Outputs, all but hresp straight from flip-flops; hresp is tied low
    assign hrdata       = st_reg.rdata;
    assign hreadyout    = st_reg.ready;
    assign hresp        = 1'b0;
    assign shadow_store = st_reg.store;
    assign dac1_cfg     = st_reg.dac1;

    // ==================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence rd_at(logic [7:0] idx);
        addr_taken && !hwrite && addr_idx == idx;
    endsequence

    sequence wr_ctrl_bit(int b);
        addr_taken && hwrite && addr_idx == IDX_DBG_CTRL
        ##1 hwdata[b];
    endsequence

    dac_reset_a: assert property ($past(nrst) == 1'b0
        |-> dac1_cfg == madr_dac1_t'(DAC1_RESET[DAC1_W-1:0]))
        else $error("DAC1 reset value wrong");
    cur_ki_a: assert property (rd_at(IDX_CUR_GAIN)
        |=> hrdata[31:16] == 16'($past(
            gains_used.current_integral_gain_used)))
        else $error("current Ki readback wrong");
    cur_kp_a: assert property (rd_at(IDX_CUR_GAIN)
        |=> hrdata[15:0] == 16'($past(
            gains_used.current_proportional_gain_used)))
        else $error("current Kp readback wrong");
    spd_ki_a: assert property (rd_at(IDX_SPD_GAIN)
        |=> hrdata[31:16] == 16'($past(
            gains_used.speed_integral_gain_used)))
        else $error("speed Ki readback wrong");
    spd_kp_a: assert property (rd_at(IDX_SPD_GAIN)
        |=> hrdata[15:0] == 16'($past(
            gains_used.speed_proportional_gain_used)))
        else $error("speed Kp readback wrong");
    ro_gain_a: assert property (addr_taken && hwrite
        && addr_idx == IDX_CUR_GAIN |=> ##1 $stable(dac1_cfg)
        && !shadow_store) else $error("gain write had an effect");
    store_pulse_a: assert property (wr_ctrl_bit(BIT_STORE)
        |=> shadow_store ##1 !shadow_store)
        else $error("store-results pulse missing");
    start_run_a: assert property (wr_ctrl_bit(BIT_START)
        ##0 meas_step == STEP_IDLE ##0 hwdata[BIT_IND]
        |=> ##1 meas_step == STEP_IND)
        else $error("measurement run did not start");
    dac_write_a: assert property (addr_taken && hwrite
        && addr_idx == IDX_DAC1 |=> ##1
        dac1_cfg == madr_dac1_t'(DAC1_W'($past(hwdata))))
        else $error("DAC1 write did not land");
    done_set_a: assert property (seq_finished |=> st_reg.done)
        else $error("done flag missed run end");
    store_cause_a: assert property (shadow_store |->
        $past(st_reg.wr_valid) && $past(st_reg.wr_idx) == IDX_DBG_CTRL)
        else $error("store pulse without a control write");
endmodule
`default_nettype wire

// ---- logic/madr_pkg.sv ----
// Package of constants and types for the motor algorithm debug registers
package madr_pkg;

    // ==================================================
    // Register indices (byte address is four times these)
    localparam logic [7:0] IDX_CUR_GAIN  = 8'hf0;
    localparam logic [7:0] IDX_SPD_GAIN  = 8'hf2;
    localparam logic [7:0] IDX_DAC1      = 8'hf4;
    localparam logic [7:0] IDX_DBG_CTRL  = 8'hea;
    localparam logic [7:0] IDX_MEAS_STS  = 8'hec;
    localparam logic [7:0] IDX_NONE      = 8'h00;

    // ==================================================
    // Field positions
    localparam int BIT_STORE   = 0;
    localparam int BIT_MECH    = 1;
    localparam int BIT_BEMF    = 2;
    localparam int BIT_IND     = 3;
    localparam int BIT_START   = 5;
    localparam int GAIN_W      = 10;
    localparam int KI_LSB      = 16;
    localparam int KP_LSB      = 0;
    localparam int STS_BUSY    = 0;
    localparam int STS_DONE    = 1;
    localparam int DAC1_W      = 21;

    // ==================================================
    // Reset values
    localparam logic [31:0] DAC1_RESET = 32'h0011_0000;

    // ==================================================
    // Types
    typedef struct packed {
        logic [3:0]  monitor1_power_scale;
        logic [3:0]  monitor1_scale;
        logic        monitor1_polarity;
        logic [11:0] monitor1_variable_address;
    } madr_dac1_t;

    typedef struct packed {
        logic inductance_select;
        logic back_emf_select;
        logic mechanical_select;
    } madr_sel_t;

    typedef struct packed {
        logic [GAIN_W-1:0] current_integral_gain_used;
        logic [GAIN_W-1:0] current_proportional_gain_used;
        logic [GAIN_W-1:0] speed_integral_gain_used;
        logic [GAIN_W-1:0] speed_proportional_gain_used;
    } madr_gains_t;

    typedef enum logic [1:0] {
        STEP_IDLE,
        STEP_IND,
        STEP_BEMF,
        STEP_MECH
    } madr_step_t;

endpackage

// ---- logic/madr_meas_seq.sv ----
// Sequencer that walks the selected parameter measurement steps
`timescale 1ns/1ps
`default_nettype none
module madr_meas_seq (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Control from the register file
    input  wire logic                 start,
    input  wire madr_pkg::madr_sel_t  sel,
    // Handshake with the estimation engine
    input  wire logic                 step_done,
    output var  madr_pkg::madr_step_t step,
    output var  logic                 finished
);
    import madr_pkg::*;

    typedef struct packed {
        madr_step_t step;
        madr_sel_t  sel;
        logic       finished;
    } madr_seq_state_t;

    madr_seq_state_t st_reg;
    madr_seq_state_t st_next;

    // First selected step after the given one; idle when none is left
    function automatic madr_step_t next_step(madr_step_t from,
                                              madr_sel_t s);
        if (from == STEP_IDLE && s.inductance_select)
            return STEP_IND;
        if ((from == STEP_IDLE || from == STEP_IND) && s.back_emf_select)
            return STEP_BEMF;
        if (from != STEP_MECH && s.mechanical_select)
            return STEP_MECH;
        return STEP_IDLE;
    endfunction

    // Start is ignored during a run, so the selects stay frozen
    always_comb begin
        st_next          = st_reg;
        st_next.finished = 1'b0;
        case (st_reg.step)
            STEP_IDLE: begin
                if (start) begin
                    st_next.sel      = sel;
                    st_next.step     = next_step(STEP_IDLE, sel);
                    st_next.finished = next_step(STEP_IDLE, sel)
                                       == STEP_IDLE;
                end
            end
            default: begin
                if (step_done) begin
                    st_next.step     = next_step(st_reg.step, st_reg.sel);
                    st_next.finished = next_step(st_reg.step, st_reg.sel)
                                       == STEP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign step     = st_reg.step;
    assign finished = st_reg.finished;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence run_launch;
        start && st_reg.step == STEP_IDLE;
    endsequence

    ind_first_a: assert property (run_launch ##0 sel.inductance_select
        |=> step == STEP_IND) else $error("inductance step not first");
    bemf_pick_a: assert property (run_launch ##0 !sel.inductance_select
        && sel.back_emf_select |=> step == STEP_BEMF)
        else $error("back-EMF step not taken");
    mech_only_a: assert property (run_launch ##0 sel == 3'b001
        |=> step == STEP_MECH) else $error("mechanical step not taken");
    empty_run_a: assert property (run_launch ##0 sel == 3'b000
        |=> finished && step == STEP_IDLE)
        else $error("empty run did not finish at once");
    sel_frozen_a: assert property (step != STEP_IDLE
        |=> $stable(st_reg.sel)) else $error("selects changed in a run");
endmodule
`default_nettype wire

// ---- bench/madr_regs_bench.sv ----
// Self-checking bench for the motor algorithm debug register bank
`timescale 1ns/1ps
`default_nettype none
module madr_regs_bench;
    import madr_pkg::*;

    // ==================================================
    // Design signals
    logic              clk;
    logic              nrst;
    logic              hsel;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    madr_gains_t       gains_used;
    logic              step_done;
    madr_step_t        meas_step;
    logic              shadow_store;
    madr_dac1_t        dac1_cfg;
    int                miscompares;
    int                check_count;
    int                store_seen;
    int                store_exp;
    logic [31:0]       rd;

    // Single slave, so its ready is the bus ready
    madr_regs dut (
        .clk          (clk),
        .nrst         (nrst),
        .hsel         (hsel),
        .haddr        (haddr),
        .htrans       (htrans),
        .hwrite       (hwrite),
        .hsize        (hsize),
        .hwdata       (hwdata),
        .hready       (hreadyout),
        .hrdata       (hrdata),
        .hreadyout    (hreadyout),
        .hresp        (hresp),
        .gains_used   (gains_used),
        .step_done    (step_done),
        .meas_step    (meas_step),
        .shadow_store (shadow_store),
        .dac1_cfg     (dac1_cfg)
    );

    // ==================================================
    // Clock and pulse counting
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (shadow_store === 1'b1) store_seen++;
    end

    // ==================================================
    // Comparison, verdict and bus tasks
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One single transfer; waits on ready, no fixed latency assumed
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rdv);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {22'h0, idx, 2'b00};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rdv = hrdata;
    endtask

    function automatic logic [31:0] pack(input logic [9:0] ki,
                                         input logic [9:0] kp);
        return {6'h0, ki, 6'h0, kp};
    endfunction

    // Expected step order, two bits per step, oldest highest
    function automatic logic [5:0] exp_seq(input logic [2:0] s);
        logic [5:0] q;
        q = 6'h0;
        if (s[2]) q = {q[3:0], 2'd1};
        if (s[1]) q = {q[3:0], 2'd2};
        if (s[0]) q = {q[3:0], 2'd3};
        return q;
    endfunction

    // Start a run; optionally rewrite the selects while it runs
    task automatic run(input logic [2:0] s, input logic clr);
        logic [5:0] q;
        logic       st;
        logic       nxt;
        st = 1'($urandom);
        store_exp += st;
        bus(1'b1, IDX_DBG_CTRL, 32'h20 | {28'h0, s, st}, rd);
        if (clr) bus(1'b1, IDX_DBG_CTRL, ~{28'h0, s, 1'b1} & 32'he, rd);
        q = 6'h0;
        nxt = 1'b0;
        repeat (24) begin
            @(posedge clk);
            step_done <= nxt;
            #1;
            nxt = 1'b0;
            if (meas_step !== STEP_IDLE && step_done === 1'b0) begin
                q = {q[3:0], 2'(meas_step)};
                nxt = 1'b1;
            end
        end
        chk("step order", {26'h0, q}, {26'h0, exp_seq(s)});
    endtask

    // ==================================================
    // Watchdog
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end

    // ==================================================
    // Main sequence
    initial begin
        logic [31:0] v;
        void'($urandom(32'h926b8c89));
        nrst = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; step_done = 1'b0;
        gains_used = 40'({$urandom, $urandom});
        miscompares = 0; check_count = 0; store_seen = 0; store_exp = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        chk("dac1 cfg rst", {11'h0, dac1_cfg}, DAC1_RESET);
        chk("ready rst", {31'h0, hreadyout}, 32'h1);
        bus(1'b0, IDX_DAC1, 32'h0, rd);
        chk("dac1 rst", rd, DAC1_RESET);
        // Gain readbacks follow the loops, writes have no effect
        repeat (3) begin
            @(posedge clk);
            gains_used <= 40'({$urandom, $urandom});
            bus(1'b1, IDX_CUR_GAIN, $urandom, rd);
            bus(1'b1, IDX_SPD_GAIN, $urandom, rd);
            bus(1'b0, IDX_CUR_GAIN, 32'h0, rd);
            chk("cur gain", rd, pack(gains_used.current_integral_gain_used,
                gains_used.current_proportional_gain_used));
            bus(1'b0, IDX_SPD_GAIN, 32'h0, rd);
            chk("spd gain", rd, pack(gains_used.speed_integral_gain_used,
                gains_used.speed_proportional_gain_used));
        end
        // Monitor register fields land on the configuration outputs
        v = $urandom & 32'h001f_ffff;
        bus(1'b1, IDX_DAC1, v | 32'hffe0_0000, rd);
        bus(1'b0, IDX_DAC1, 32'h0, rd);
        chk("dac1 rd", rd, v);
        chk("dac1 cfg", {11'h0, dac1_cfg}, v);
        bus(1'b0, 8'h10, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        // Lone store request without a run
        bus(1'b1, IDX_DBG_CTRL, 32'h1, rd);
        store_exp++;
        bus(1'b0, IDX_DBG_CTRL, 32'h0, rd);
        chk("ctrl rd", rd, 32'h0);
        // Every select combination, half with selects inverted mid-run
        for (int i = 0; i < 8; i++) run(3'(i), i[0]);
        repeat (4) run(3'($urandom), 1'($urandom));
        // Status: done stays set after a run until written with 1
        bus(1'b0, IDX_MEAS_STS, 32'h0, rd);
        chk("sts done", rd, 32'h1 << STS_DONE);
        bus(1'b1, IDX_MEAS_STS, 32'h1 << STS_DONE, rd);
        bus(1'b0, IDX_MEAS_STS, 32'h0, rd);
        chk("sts clear", rd, 32'h0);
        repeat (4) @(posedge clk);
        chk("store pulses", 32'(store_seen), 32'(store_exp));
        chk("hresp", {31'h0, hresp}, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
